// File: spram_wm.sv
// Single-port RAM with selectable write modes and an AHB-Lite control port
`timescale 1ns/100ps
`include "spram_params.svh"

module spram_wm
	import spram_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ram_req_t req,
	input wire logic out_rst,
	output word_t dout
);

	// =================================================================
	// Constants and conversion
	localparam int LAT = `SPRAM_LAT;
	localparam logic [1:0] MTYPE = `SPRAM_MTYPE;
	localparam logic signed [31:0] INIT_VEC [`SPRAM_INIT_LEN] =
		`SPRAM_INIT_VEC;
	localparam logic LAT_OK = (LAT >= 1);

	// Round half up, then clamp to the data port's range
	function automatic word_t sat_round(input logic signed [31:0] v);
		logic signed [31:0] r;
		r = (v + `SPRAM_ROUND) >>> `SPRAM_FRAC;
		if (r > `SPRAM_SAT_MAX) begin
			r = `SPRAM_SAT_MAX;
		end else if (r < `SPRAM_SAT_MIN) begin
			r = `SPRAM_SAT_MIN;
		end
		return word_t'(r[`SPRAM_DW-1:0]);
	endfunction : sat_round

	// Power-up word for one location
	function automatic word_t init_word(input int i);
		word_t w;
		w = `SPRAM_ZERO;
		if (MTYPE != `SPRAM_MT_LARGE && i < `SPRAM_INIT_LEN) begin
			w = sat_round(INIT_VEC[i]);
		end
		return w;
	endfunction : init_word

	localparam word_t OUT_INIT = (MTYPE == `SPRAM_MT_LARGE) ?
		`SPRAM_ZERO : sat_round(`SPRAM_OUT_INIT);

	// =================================================================
	// Storage
	word_t mem [`SPRAM_DEPTH];
	wmode_t mode;
	word_t rd_old;
	word_t q0;
	word_t next_q0;
	logic rst_eff;

	// Address stays in range by the caller's contract
	assign rd_old = mem[req.addr];
	assign rst_eff = out_rst & LAT_OK;

	// One flip-flop word per location, loaded from the initial vector except in large builds, zero past its end
	genvar gi;
	generate
		for (gi = 0; gi < `SPRAM_DEPTH; gi++) begin : g_word
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					mem[gi] <= init_word(gi);
				end else if (req.we &&
					req.addr == `SPRAM_AW'(gi)) begin
					mem[gi] <= req.din;
				end
			end
		end
	endgenerate

	// =================================================================
	// First output stage: write-mode selection
	always_comb begin
		next_q0 = rd_old;
		if (req.we) begin
			unique case (mode)
				WM_RAW: next_q0 = req.din;
				WM_RBW: next_q0 = rd_old;
				default: next_q0 = q0;
			endcase
		end
	end

	// Output reset leaves the memory alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q0 <= OUT_INIT;
		end else if (rst_eff) begin
			q0 <= OUT_INIT;
		end else begin
			q0 <= next_q0;
		end
	end

	// Further latency stages
	word_t stg [LAT];
	assign stg[0] = q0;
	genvar gk;
	generate
		for (gk = 1; gk < LAT; gk++) begin : g_lat
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					stg[gk] <= OUT_INIT;
				end else if (rst_eff) begin
					stg[gk] <= OUT_INIT;
				end else begin
					stg[gk] <= stg[gk-1];
				end
			end
		end
	endgenerate
	assign dout = stg[LAT-1];

	// =================================================================
	// AHB-Lite slave: zero wait states, always OKAY
	logic take;
	logic wr_pend;
	logic [7:0] wr_ofs;
	logic rej;
	logic [1:0] new_mode;
	logic mode_ok;
	logic ctrl_wr;
	logic stat_wr;
	logic [31:0] rd_mux;
	logic [7:0] a_ofs;

	assign hreadyout = 1'b1;
	assign hresp = `SPRAM_HRESP_OKAY;
	assign take = hsel & htrans[1] & hready;
	assign a_ofs = haddr[7:0];
	assign new_mode = hwdata[`SPRAM_MODE_MSB:`SPRAM_MODE_LSB];
	assign ctrl_wr = wr_pend && wr_ofs == `SPRAM_CTRL_OFS;
	assign stat_wr = wr_pend && wr_ofs == `SPRAM_STAT_OFS;

	// Distributed memory supports only what its output path can build
	assign mode_ok = new_mode != `SPRAM_WM_BAD &&
		!(MTYPE == `SPRAM_MT_DIST && (new_mode == `SPRAM_WM_NRW ||
		(new_mode == `SPRAM_WM_RAW && !LAT_OK)));

	// Register read selection; unmapped offsets read zero
	assign rd_mux =
		(a_ofs == `SPRAM_CTRL_OFS) ? {30'h0, mode} :
		(a_ofs == `SPRAM_STAT_OFS) ? {26'h0, MTYPE, 1'b0, rej, 2'h0} :
		(a_ofs == `SPRAM_DOUT_OFS) ? {{16{dout[15]}}, dout} : 32'h0;

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_ofs <= 8'h00;
			hrdata <= 32'h0;
		end else begin
			wr_pend <= take & hwrite & (hsize == `SPRAM_SIZE_WORD);
			wr_ofs <= a_ofs;
			if (take & !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Mode register, refused writes leave it unchanged
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= WM_RBW;
		end else if (ctrl_wr && mode_ok) begin
			mode <= wmode_t'(new_mode);
		end
	end

	// Sticky refusal flag, set wins over write-one-to-clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rej <= 1'b0;
		end else if (ctrl_wr && !mode_ok) begin
			rej <= 1'b1;
		end else if (stat_wr && hwdata[`SPRAM_REJ_BIT]) begin
			rej <= 1'b0;
		end
	end

	// =================================================================
	// Assertions
	// A write lands in the addressed word
	AST_WRITE_STORES: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.we |=> mem[$past(req.addr)] == $past(req.din))
		else $error("written word not stored");

	// Without a write the addressed word keeps its value
	AST_MEM_HOLD: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!req.we |=> mem[$past(req.addr)] == $past(rd_old))
		else $error("memory changed without a write");

	// Plain reads load the addressed word into the first stage
	AST_READ_IDLE: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!req.we && !out_rst |=> q0 == $past(rd_old))
		else $error("idle read shows wrong word");

	// Read-after-write shows the new word
	AST_RAW: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.we && mode == WM_RAW && !out_rst |=>
		q0 == $past(req.din))
		else $error("read-after-write output wrong");

	// Read-before-write shows the old word
	AST_RBW: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.we && mode == WM_RBW && !out_rst |=>
		q0 == $past(rd_old) && q0 != $past(req.din) ||
		q0 == $past(req.din) && $past(rd_old) == $past(req.din))
		else $error("read-before-write output wrong");

	// No-read-on-write keeps the first stage still
	AST_NRW: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.we && mode == WM_NRW && !out_rst |=> $stable(q0))
		else $error("no-read-on-write output moved");

	// No-read-on-write still stores the word
	AST_NRW_STORES: assert property (
		@(posedge hclk) disable iff (!hresetn)
		req.we && mode == WM_NRW |=>
		mem[$past(req.addr)] == $past(req.din))
		else $error("no-read-on-write lost the word");

	// The output trails the first stage by one cycle less than the latency
	AST_LATENCY: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!out_rst && !$past(out_rst) |-> dout == $past(q0, LAT-1))
		else $error("output latency wrong");

	// The last stage copies the one before it
	AST_DOUT_STAGE: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!out_rst |=> dout == $past(stg[LAT-2]))
		else $error("output stage did not shift");

	// Output reset sets the output, memory untouched
	AST_OUT_RST: assert property (
		@(posedge hclk) disable iff (!hresetn)
		out_rst && !req.we |=> dout == OUT_INIT &&
		mem[$past(req.addr)] == $past(rd_old))
		else $error("output reset misbehaved");

	// Output reset also sets the first stage
	AST_OUT_RST_Q0: assert property (
		@(posedge hclk) disable iff (!hresetn)
		out_rst |=> q0 == OUT_INIT)
		else $error("output reset missed first stage");

	// A write during output reset still lands
	AST_OUT_RST_MEM: assert property (
		@(posedge hclk) disable iff (!hresetn)
		out_rst && req.we |=> mem[$past(req.addr)] == $past(req.din))
		else $error("output reset blocked a write");

	// Refused modes set the flag and keep the mode
	AST_MODE_LEGAL: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ctrl_wr && !mode_ok |=> rej && $stable(mode))
		else $error("illegal mode accepted");

	// Accepted modes take effect
	AST_MODE_WRITE: assert property (
		@(posedge hclk) disable iff (!hresetn)
		ctrl_wr && mode_ok |=> mode == $past(new_mode))
		else $error("legal mode not taken");

	// The mode moves only on a control write
	AST_MODE_HOLD: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!ctrl_wr |=> $stable(mode))
		else $error("mode changed without a write");

	// Write one clears the refusal flag
	AST_REJ_CLEAR: assert property (
		@(posedge hclk) disable iff (!hresetn)
		stat_wr && hwdata[`SPRAM_REJ_BIT] |=> !rej)
		else $error("refusal flag not cleared");

	// The refusal flag holds between register writes
	AST_REJ_HOLD: assert property (
		@(posedge hclk) disable iff (!hresetn)
		!ctrl_wr && !stat_wr |=> $stable(rej))
		else $error("refusal flag moved");

	// A taken read returns the selected register
	AST_HRDATA_READ: assert property (
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite |=> hrdata == $past(rd_mux))
		else $error("read data wrong");

	// Distributed builds never run unsupported modes
	AST_DIST_MODE: assert property (
		@(posedge hclk) disable iff (!hresetn)
		MTYPE == `SPRAM_MT_DIST |-> mode != WM_NRW && mode != WM_BAD)
		else $error("distributed memory in unsupported mode");

	// Distributed read-after-write needs a registered output
	AST_RAW_DIST_LAT: assert property (
		@(posedge hclk) disable iff (!hresetn)
		MTYPE == `SPRAM_MT_DIST && !LAT_OK |-> mode != WM_RAW)
		else $error("distributed read-after-write without latency");

endmodule : spram_wm

// File: spram_params.svh
// Constants of the single-port RAM with write modes
`ifndef SPRAM_PARAMS_SVH
`define SPRAM_PARAMS_SVH

// =====================================================================
// Geometry and latency
`define SPRAM_DEPTH 16
`define SPRAM_AW 4
`define SPRAM_DW 16
`define SPRAM_LAT 2

// =====================================================================
// Memory resource and write mode codes
`define SPRAM_MT_DIST 2'h0
`define SPRAM_MT_BLOCK 2'h1
`define SPRAM_MT_LARGE 2'h2
`define SPRAM_MTYPE 2'h1
`define SPRAM_WM_RAW 2'h0
`define SPRAM_WM_RBW 2'h1
`define SPRAM_WM_NRW 2'h2
`define SPRAM_WM_BAD 2'h3

// =====================================================================
// Initial contents, two fraction bits beyond the data port
`define SPRAM_INIT_LEN 6
`define SPRAM_INIT_VEC '{32'sh00000016, 32'sh0003FFFF, 32'shFFFFFFF3, \
	32'sh00000005, 32'shFFFC0000, 32'sh00000102}
`define SPRAM_OUT_INIT 32'sh0000001B
`define SPRAM_FRAC 2
`define SPRAM_ROUND 32'sh00000002
`define SPRAM_SAT_MAX 32'sh00007FFF
`define SPRAM_SAT_MIN 32'shFFFF8000
`define SPRAM_ZERO 16'h0000

// =====================================================================
// Register map and fields
`define SPRAM_CTRL_OFS 8'h00
`define SPRAM_STAT_OFS 8'h04
`define SPRAM_DOUT_OFS 8'h08
`define SPRAM_MODE_MSB 1
`define SPRAM_MODE_LSB 0
`define SPRAM_REJ_BIT 2
`define SPRAM_MT_MSB 5
`define SPRAM_MT_LSB 4
`define SPRAM_SIZE_WORD 3'h2
`define SPRAM_HRESP_OKAY 1'h0

`endif

// File: spram_pkg.sv
// Types shared by the single-port RAM
`include "spram_params.svh"
package spram_pkg;
	typedef enum logic [1:0] {
		WM_RAW = `SPRAM_WM_RAW,
		WM_RBW = `SPRAM_WM_RBW,
		WM_NRW = `SPRAM_WM_NRW,
		WM_BAD = `SPRAM_WM_BAD
	} wmode_t;

	// One word: one type, width and binary point for all locations
	typedef logic signed [`SPRAM_DW-1:0] word_t;

	typedef struct packed {
		logic we;
		logic [`SPRAM_AW-1:0] addr;
		word_t din;
	} ram_req_t;
endpackage : spram_pkg

// File: spram_user_model.sv
// Model of the user logic that drives the RAM port
`timescale 1ns/100ps
`include "spram_params.svh"

module spram_user_model
	import spram_pkg::*;
(
	input wire logic hclk,
	output ram_req_t req,
	output logic out_rst
);
	// =============================================================
	// Idle port: reads of word zero, output stages left alone
	initial begin
		req = '0;
		out_rst = 1'h0;
	end

	// One access; the address is folded into the depth
	task access(input logic we, input int a, input logic [15:0] d);
		req.we <= we;
		req.addr <= `SPRAM_AW'(a % `SPRAM_DEPTH);
		// Data is meaningless on reads, so it shows the inverse
		req.din <= we ? word_t'(d) : word_t'(~d);
	endtask : access

	// Clear the output stages for exactly one edge
	task clear_out;
		out_rst <= 1'h1;
		@(posedge hclk);
		out_rst <= 1'h0;
	endtask : clear_out
endmodule : spram_user_model

// File: tb_top.sv
// Testbench of the single-port RAM with write modes
`timescale 1ns/100ps
`include "spram_params.svh"

module tb_top
	import spram_pkg::*;
;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	ram_req_t req;
	logic out_rst;
	word_t dout;
	int errors = 0;
	int n_checks = 0;
	logic [15:0] init_exp [8] = '{16'h0006, 16'h7FFF, 16'hFFFD, 16'h0001,
		16'h8000, 16'h0041, 16'h0000, 16'h0000};

	// =============================================================
	// Clock, single slave bus and instances
	always #10 hclk = ~hclk;
	assign hready = hreadyout;

	spram_user_model spram_user_model_inst (.hclk(hclk), .req(req),
		.out_rst(out_rst));

	spram_wm spram_wm_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .req(req), .out_rst(out_rst),
		.dout(dout));

	// =============================================================
	// Verdict and end of run
	task summarize;
		if (errors == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Wait for hready under a bound
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(posedge hclk);
			i++;
		end while (hready !== 1'h1 && i < 50);
		if (i >= 50) begin
			errors++;
			summarize();
		end
	endtask : wait_rdy

	// One single AHB-Lite transfer; read data lands in rd
	task ahb(input logic w, input logic [2:0] sz, input logic [31:0] a,
		input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : ahb

	// One RAM access, output checked one edge after sampling
	task ram(input logic we, input int a, input logic [15:0] d,
		input logic [15:0] exp);
		@(posedge hclk);
		spram_user_model_inst.access(we, a, d);
		@(posedge hclk);
		spram_user_model_inst.access(1'h0, a, d);
		@(posedge hclk);
		#1;
		chk("dout", {16'h0, exp}, {16'h0, dout});
	endtask : ram

	// =============================================================
	// Main sequence
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'h1;
		#1;
		chk("dout_init", 32'h7, {16'h0, dout});
		ahb(1'h0, 3'h2, 32'h0, 32'h0);
		chk("ctrl", 32'h1, rd);
		ahb(1'h0, 3'h2, 32'h4, 32'h0);
		chk("status", 32'h10, rd);
		ahb(1'h0, 3'h2, 32'hC, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hreadyout", 32'h1, {31'h0, hreadyout});
		ahb(1'h1, 3'h0, 32'h0, 32'h0);
		ahb(1'h0, 3'h2, 32'h0, 32'h0);
		chk("ctrl_size", 32'h1, rd);
		for (int i = 0; i < 8; i++) begin
			ram(1'h0, i, 16'h0, init_exp[i]);
		end
		ram(1'h0, 15, 16'h0, 16'h0);
		ram(1'h0, 4, 16'h0, 16'h8000);
		ahb(1'h0, 3'h2, 32'h8, 32'h0);
		chk("dout_reg", 32'hFFFF8000, rd);
		ram(1'h1, 6, 16'h1234, 16'h0000);
		ram(1'h0, 6, 16'h0, 16'h1234);
		ahb(1'h1, 3'h2, 32'h0, 32'h0);
		ram(1'h1, 6, 16'h5555, 16'h5555);
		ahb(1'h1, 3'h2, 32'h0, 32'h2);
		ram(1'h1, 7, 16'h0AAA, 16'h5555);
		ram(1'h0, 7, 16'h0, 16'h0AAA);
		ahb(1'h1, 3'h2, 32'h0, 32'h3);
		ahb(1'h0, 3'h2, 32'h4, 32'h0);
		chk("status_rej", 32'h14, rd);
		ahb(1'h0, 3'h2, 32'h0, 32'h0);
		chk("ctrl_kept", 32'h2, rd);
		ahb(1'h1, 3'h2, 32'h4, 32'h4);
		ahb(1'h0, 3'h2, 32'h4, 32'h0);
		chk("status_clr", 32'h10, rd);
		@(posedge hclk);
		spram_user_model_inst.clear_out();
		#1;
		chk("dout_rst", 32'h7, {16'h0, dout});
		ram(1'h0, 7, 16'h0, 16'h0AAA);
		summarize();
	end

	// Cut a hang short
	initial begin
		#100000;
		errors++;
		summarize();
	end
endmodule : tb_top
